// File: hw/mac_alu.sv
// combinational datapath: 40-bit subtract variants, logical shift right, flags
`timescale 1ns/1ps
module mac_alu import mac_sub_pkg::*; (
    mac_dec_if.sink                 dec,      // decoded fields
    input  wire logic [ACC_W-1:0]   acc_i,    // current accumulator
    input  wire logic [WORD_W-1:0]  op_lo_i,  // first source word
    input  wire logic [WORD_W-1:0]  op_hi_i,  // second source word
    input  wire logic [FLAG_W-1:0]  flags_i,  // current flags
    input  wire logic               sat_en_i, // saturation enable
    output logic      [ACC_W-1:0]   res_o,    // new accumulator
    output logic      [FLAG_W-1:0]  flags_o   // new flags
);
    logic [ACC_W:0]   opnd, a, mn, sb, diff;
    logic [ACC_W-1:0] shr;
    logic [CNT_W-1:0] cnt;
    logic             ovf, brw, sat;

    always_comb begin
        opnd = {op_hi_i[WORD_W-1], sext_operand(op_hi_i, op_lo_i)};
        if (dec.dbl) begin
            opnd = {opnd[ACC_W-1:0], 1'b0};
        end
        a    = {acc_i[ACC_W-1], acc_i};
        mn   = dec.rev ? opnd : a;
        sb   = dec.rev ? a : opnd;
        diff = mn - sb;
        brw  = mn[ACC_W-1:0] < sb[ACC_W-1:0];
        ovf  = diff[ACC_W] ^ diff[ACC_W-1];
        // limits are 32-bit so the guard byte never holds magnitude once saturated
        sat  = sat_en_i && ($signed(diff) > $signed({1'b0, SAT_POS})
                         || $signed(diff) < $signed({1'b1, SAT_NEG}));
        cnt  = dec.cnt_imm ? dec.cnt : {1'b0, op_lo_i[REG_CNT_W-1:0]};
        shr  = acc_i >> cnt;
        res_o   = acc_i;
        flags_o = flags_i;
        case (dec.kind)
            K_SHR: begin
                res_o        = shr;
                flags_o[F_V] = 1'b0;
                flags_o[F_C] = 1'b0;
            end
            K_SUB: begin
                res_o         = sat ? (diff[ACC_W] ? SAT_NEG : SAT_POS) : diff[ACC_W-1:0];
                flags_o[F_V]  = ovf;
                flags_o[F_C]  = brw;
                flags_o[F_SV] = flags_i[F_SV] | ovf;
                flags_o[F_SL] = flags_i[F_SL] | sat;
            end
            default: begin
                res_o = acc_i;
            end
        endcase
        if (dec.kind == K_SHR || dec.kind == K_SUB) begin
            flags_o[F_E] = guard_used(res_o);
            flags_o[F_Z] = (res_o == '0);
            flags_o[F_N] = res_o[ACC_W-1];
        end
    end
endmodule // mac_alu

// File: hw/mac_dec_if.sv
// decoded instruction fields shared by the decoder, datapath and top
`timescale 1ns/1ps
interface mac_dec_if import mac_sub_pkg::*; ();
    op_kind_e               kind;
    logic                   dbl;
    logic                   rev;
    logic                   cnt_imm;
    logic                   ind;
    logic [CNT_W-1:0]       cnt;
    logic [SEL_W-1:0]       sel;
    logic [QQQ_W-1:0]       qqq;
    logic [BYTE_W-1:0]      dest;
    modport src  (output kind, dbl, rev, cnt_imm, ind, cnt, sel, qqq, dest);
    modport sink (input  kind, dbl, rev, cnt_imm, ind, cnt, sel, qqq, dest);
endinterface

// File: hw/mac_decode.sv
// opcode decoder for shift right, register store and the four subtract forms
`timescale 1ns/1ps
module mac_decode import mac_sub_pkg::*; (
    input  wire logic [INSTR_W-1:0] instr_i, // first byte in bits 7:0
    mac_dec_if.src                  dec      // decoded fields
);
    logic [BYTE_W-1:0] b0, b1, b2, b3;
    logic              ari;

    assign {b3, b2, b1, b0} = instr_i;
    assign ari = (b0 == OP_RR) || (b0 == OP_RI) || (b0 == OP_XI);

    always_comb begin
        dec.kind    = K_NONE;
        dec.dbl     = (b2 == B2_SUB2) || (b2 == B2_SUB2R);
        dec.rev     = (b2 == B2_SUBR) || (b2 == B2_SUB2R);
        dec.cnt_imm = (b2 == B2_SHR_IMM);
        dec.cnt     = b3[CNT_W-1:0];
        dec.ind     = (b0 == OP_RI) || (b0 == OP_XI) || (b0 == OP_ST_IND);
        dec.sel     = b2[BYTE_W-1 -: SEL_W];
        dec.qqq     = b3[QQQ_W-1:0];
        dec.dest    = b1;
        case (b2)
            B2_SUB, B2_SUB2, B2_SUB2R, B2_SUBR: begin
                if (ari) begin
                    dec.kind = K_SUB;
                end
            end
            B2_SHR_IMM: begin
                if (b0 == OP_RR && b1 == B1_ZERO && b3[CNT_W-1:0] <= SHR_MAX_IMM) begin
                    dec.kind = K_SHR;
                end
            end
            B2_SHR_REG: begin
                if (b0 == OP_RR || b0 == OP_RI) begin
                    dec.kind = K_SHR;
                end
            end
            default: begin
                dec.kind = K_NONE;
            end
        endcase
        // store byte 2 carries a register number, so it overrides the table above
        if (b0 == OP_ST_DIR || b0 == OP_ST_IND) begin
            dec.kind = K_STORE;
        end
    end
endmodule // mac_decode

// File: hw/mac_sub_pkg.sv
// shared constants, types and helpers for the accumulator subtract/shift/store block
package mac_sub_pkg;
    localparam int ACC_W     = 40;
    localparam int WORD_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int INSTR_W   = 32;
    localparam int FLAG_W    = 7;
    localparam int SEL_W     = 5;
    localparam int CNT_W     = 5;
    localparam int REG_CNT_W = 4;
    localparam int QQQ_W     = 3;
    localparam int GUARD_LSB = 32;
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 8;
    localparam int STAT_W    = 16;
    localparam logic [7:0] OP_RR      = 8'ha3;
    localparam logic [7:0] OP_RI      = 8'h83;
    localparam logic [7:0] OP_XI      = 8'h93;
    localparam logic [7:0] OP_ST_DIR  = 8'hc3;
    localparam logic [7:0] OP_ST_IND  = 8'hb3;
    localparam logic [7:0] B1_ZERO    = 8'h00;
    localparam logic [7:0] B2_SHR_IMM = 8'h92;
    localparam logic [7:0] B2_SHR_REG = 8'h9a;
    localparam logic [7:0] B2_SUB     = 8'h0a;
    localparam logic [7:0] B2_SUB2    = 8'h4a;
    localparam logic [7:0] B2_SUB2R   = 8'h52;
    localparam logic [7:0] B2_SUBR    = 8'h12;
    localparam logic [CNT_W-1:0] SHR_MAX_IMM = 5'h10;
    localparam int F_N = 0, F_Z = 1, F_C = 2, F_SV = 3, F_E = 4, F_SL = 5, F_V = 6;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
    localparam logic [ACC_W-1:0]  SAT_POS   = 40'h007fffffff;
    localparam logic [ACC_W-1:0]  SAT_NEG   = 40'hff80000000;
    localparam logic [SEL_W-1:0] CSEL_ACC_LOW = 5'h00;
    localparam logic [SEL_W-1:0] CSEL_ACC_MID = 5'h01;
    localparam logic [SEL_W-1:0] CSEL_GUARD   = 5'h02;
    localparam logic [SEL_W-1:0] CSEL_FLAGS   = 5'h03;
    localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] A_ACC_LO = 8'h04;
    localparam logic [ADDR_W-1:0] A_ACC_HI = 8'h08;
    localparam logic [ADDR_W-1:0] A_FLAGS  = 8'h0c;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h10;
    typedef enum logic [1:0] {K_NONE, K_SHR, K_SUB, K_STORE} op_kind_e;
    typedef enum logic [1:0] {S_IDLE = 2'b00, S_WAIT = 2'b01, S_DONE = 2'b11} apb_state_e;

    function automatic logic guard_used(input logic [ACC_W-1:0] r);
        return !((&r[ACC_W-1:GUARD_LSB-1]) || !(|r[ACC_W-1:GUARD_LSB-1]));
    endfunction

    function automatic logic [ACC_W-1:0] sext_operand(input logic [WORD_W-1:0] hi,
                                                      input logic [WORD_W-1:0] lo);
        return {{(ACC_W-2*WORD_W){hi[WORD_W-1]}}, hi, lo};
    endfunction
endpackage

// File: hw/mac_sub_top.sv
// accumulator shift-right, register store and subtract unit with an APB register slave
// Overview of operation
// - shift right decodes from A3 00 92 immediate, A3 nn 9A register, 83 9A indirect
// - shift right clears overflow and carry, keeps both sticky flags, never saturates
// - guard-use flag set when result occupies the guard byte, else cleared
// - zero flag set for a zero result, cleared otherwise
// - negative flag copies bit 39 of the result
// - store copies one coprocessor word out, flags and accumulator untouched
// - store opcode C3 direct or B3 indirect, register select in byte 2 bits 7:3
// - plain subtract writes accumulator minus operand back into the accumulator
// - operand is second word over first word, sign-extended to 40 bits
// - doubled forms shift the operand left by one before subtracting
// - reversed forms compute operand minus accumulator
// - overflow flag set when the difference leaves the 40-bit signed range
// - sticky overflow flag set on overflow, otherwise kept
// - saturate when enabled; sticky limit flag set on saturation, otherwise kept
// - carry flag set on a borrow out of 40 bits, cleared otherwise
// - plain subtract byte 2 is 0A with first byte A3, 83 or 93
// - doubled subtract byte 2 is 4A with first byte A3, 83 or 93
// - doubled reversed subtract byte 2 is 52 with first byte A3, 83 or 93
// - reversed subtract byte 2 is 12 with first byte A3, 83 or 93
// - shift fills zeros; immediate count 0 to 16, register count low four bits
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module mac_sub_top import mac_sub_pkg::*; (
    input  wire logic                clock_i,         // 100 MHz core clock
    input  wire logic                rst_i,           // async reset, active high
    input  wire logic                psel_i,          // apb select
    input  wire logic                penable_i,       // apb access phase
    input  wire logic                pwrite_i,        // apb write
    input  wire logic [ADDR_W-1:0]   paddr_i,         // apb byte address
    input  wire logic [DATA_W-1:0]   pwdata_i,        // apb write data
    output logic      [DATA_W-1:0]   prdata_o,        // apb read data
    output logic                     pready_o,        // apb ready
    output logic                     pslverr_o,       // apb error, unmapped address
    input  wire logic                instr_valid_i,   // instruction issued this cycle
    input  wire logic [INSTR_W-1:0]  instr_i,         // instruction, first byte low
    input  wire logic [WORD_W-1:0]   op_lo_i,         // first source word or count
    input  wire logic [WORD_W-1:0]   op_hi_i,         // second source word
    output logic                     store_valid_o,   // store word ready, pulse
    output logic [WORD_W-1:0]        store_data_o,    // stored coprocessor word
    output logic                     store_ind_o,     // destination is indirect
    output logic [BYTE_W-1:0]        store_dest_o,    // destination byte nn
    output logic                     post_mod_valid_o,// pointer update due, pulse
    output logic [QQQ_W-1:0]         post_mod_code_o, // pointer update code
    output logic                     illegal_o,       // unknown opcode, pulse
    output logic [ACC_W-1:0]         acc_o,           // accumulator
    output logic [FLAG_W-1:0]        flags_o          // coprocessor flags
);
    mac_dec_if dec_bus ();

    apb_state_e          state_q;
    logic [ACC_W-1:0]    acc_q;
    logic [FLAG_W-1:0]   flags_q;
    logic                sat_en_q;
    logic [STAT_W-1:0]   exec_cnt_q;
    logic [DATA_W-1:0]   prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic                store_valid_q;
    logic [WORD_W-1:0]   store_data_q;
    logic                store_ind_q;
    logic [BYTE_W-1:0]   store_dest_q;
    logic                post_mod_valid_q;
    logic [QQQ_W-1:0]    post_mod_code_q;
    logic                illegal_q;
    logic [ACC_W-1:0]    alu_res;
    logic [FLAG_W-1:0]   alu_flags;
    logic [DATA_W-1:0]   rd_mux;
    logic                rd_hit;
    logic                exec_acc;
    logic                exec_store;
    logic                commit_wr;
    logic [WORD_W-1:0]   copro_word;
    logic [ACC_W-1:0]    plain_diff;

    mac_decode u_decode (
        .instr_i (instr_i),
        .dec     (dec_bus.src)
    );

    mac_alu u_alu (
        .dec      (dec_bus.sink),
        .acc_i    (acc_q),
        .op_lo_i  (op_lo_i),
        .op_hi_i  (op_hi_i),
        .flags_i  (flags_q),
        .sat_en_i (sat_en_q),
        .res_o    (alu_res),
        .flags_o  (alu_flags)
    );

    assign exec_acc   = instr_valid_i && (dec_bus.kind == K_SHR || dec_bus.kind == K_SUB);
    assign exec_store = instr_valid_i && (dec_bus.kind == K_STORE);
    assign commit_wr  = (state_q == S_DONE) && psel_i && penable_i && pwrite_i;
    assign plain_diff = acc_q - sext_operand(op_hi_i, op_lo_i);

    // apb slave: waits while an instruction is being issued so core updates win
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (psel_i && penable_i) begin
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (!instr_valid_i) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        case (paddr_i)
            A_CTRL: begin
                rd_mux[0] = sat_en_q;
            end
            A_ACC_LO: begin
                rd_mux = acc_q[DATA_W-1:0];
            end
            A_ACC_HI: begin
                rd_mux[ACC_W-DATA_W-1:0] = acc_q[ACC_W-1:DATA_W];
            end
            A_FLAGS: begin
                rd_mux[FLAG_W-1:0] = flags_q;
            end
            A_STATUS: begin
                rd_mux[STAT_W-1:0] = exec_cnt_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (state_q == S_WAIT && !instr_valid_i) begin
            pready_q  <= 1'b1;
            pslverr_q <= !rd_hit;
            prdata_q  <= pwrite_i ? '0 : rd_mux;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sat_en_q <= 1'b0;
        end else if (commit_wr && paddr_i == A_CTRL) begin
            sat_en_q <= pwdata_i[0];
        end
    end

    // an instruction in the commit cycle overrides a software write of the same state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= '0;
        end else if (exec_acc) begin
            acc_q <= alu_res;
        end else if (commit_wr && paddr_i == A_ACC_LO) begin
            acc_q[DATA_W-1:0] <= pwdata_i;
        end else if (commit_wr && paddr_i == A_ACC_HI) begin
            acc_q[ACC_W-1:DATA_W] <= pwdata_i[ACC_W-DATA_W-1:0];
        end
    end

    // flags are write-one-to-clear; a hardware set in the same cycle wins
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= FLAGS_RST;
        end else if (exec_acc) begin
            flags_q <= alu_flags;
        end else if (commit_wr && paddr_i == A_FLAGS) begin
            flags_q <= flags_q & ~pwdata_i[FLAG_W-1:0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            exec_cnt_q <= '0;
        end else if (instr_valid_i && dec_bus.kind != K_NONE) begin
            exec_cnt_q <= exec_cnt_q + 1'b1;
        end
    end

    always_comb begin
        case (dec_bus.sel)
            CSEL_ACC_LOW: begin
                copro_word = acc_q[WORD_W-1:0];
            end
            CSEL_ACC_MID: begin
                copro_word = acc_q[DATA_W-1:WORD_W];
            end
            CSEL_GUARD: begin
                copro_word = {{(WORD_W-BYTE_W){1'b0}}, acc_q[ACC_W-1:DATA_W]};
            end
            CSEL_FLAGS: begin
                copro_word = {{(WORD_W-FLAG_W){1'b0}}, flags_q};
            end
            default: begin
                copro_word = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            store_valid_q <= 1'b0;
            store_data_q  <= '0;
            store_ind_q   <= 1'b0;
            store_dest_q  <= '0;
        end else begin
            store_valid_q <= exec_store;
            if (exec_store) begin
                store_data_q <= copro_word;
                store_ind_q  <= dec_bus.ind;
                store_dest_q <= dec_bus.dest;
            end
        end
    end

    // the address unit performs the update; this block only names it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            post_mod_valid_q <= 1'b0;
            post_mod_code_q  <= '0;
        end else begin
            post_mod_valid_q <= instr_valid_i && dec_bus.ind && dec_bus.kind != K_NONE;
            post_mod_code_q  <= dec_bus.qqq;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= instr_valid_i && dec_bus.kind == K_NONE;
        end
    end

    assign prdata_o         = prdata_q;
    assign pready_o         = pready_q;
    assign pslverr_o        = pslverr_q;
    assign store_valid_o    = store_valid_q;
    assign store_data_o     = store_data_q;
    assign store_ind_o      = store_ind_q;
    assign store_dest_o     = store_dest_q;
    assign post_mod_valid_o = post_mod_valid_q;
    assign post_mod_code_o  = post_mod_code_q;
    assign illegal_o        = illegal_q;
    assign acc_o            = acc_q;
    assign flags_o          = flags_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_shr_clears_vc: assert property (
        instr_valid_i && dec_bus.kind == K_SHR |=> !flags_q[F_V] && !flags_q[F_C]
            && flags_q[F_SL] == $past(flags_q[F_SL]) && flags_q[F_SV] == $past(flags_q[F_SV]))
        else $error("shift right left overflow, carry or sticky flags wrong");

    a_guard_flag_match: assert property (
        exec_acc |=> flags_q[F_E] == guard_used(acc_q))
        else $error("guard-use flag disagrees with the accumulator");

    a_zero_flag_match: assert property (
        exec_acc |=> flags_q[F_Z] == (acc_q == '0))
        else $error("zero flag disagrees with the accumulator");

    a_neg_flag_match: assert property (
        exec_acc |=> flags_q[F_N] == acc_q[ACC_W-1])
        else $error("negative flag disagrees with accumulator bit 39");

    a_store_keeps_state: assert property (
        exec_store && !commit_wr |=> store_valid_o && $stable(flags_q) && $stable(acc_q))
        else $error("store changed coprocessor state or gave no word");

    a_plain_sub_value: assert property (
        instr_valid_i && dec_bus.kind == K_SUB && !dec_bus.dbl && !dec_bus.rev && !sat_en_q
            |=> acc_q == $past(plain_diff))
        else $error("plain subtract produced a wrong difference");

    a_sticky_ovf_keep: assert property (
        instr_valid_i && dec_bus.kind == K_SUB
            |=> flags_q[F_SV] == ($past(flags_q[F_SV]) | flags_q[F_V]))
        else $error("sticky overflow flag not accumulated from overflow");

    a_post_mod_code: assert property (
        instr_valid_i && dec_bus.ind && dec_bus.kind != K_NONE
            |=> post_mod_valid_o
                && post_mod_code_o == $past(instr_i[INSTR_W-BYTE_W+QQQ_W-1:INSTR_W-BYTE_W]))
        else $error("pointer update code not reported after indirect form");

    a_apb_answer_bound: assert property (
        state_q == S_WAIT && !instr_valid_i |=> pready_o ##1 !pready_o)
        else $error("apb answer not given for exactly one cycle");

    a_illegal_no_change: assert property (
        instr_valid_i && dec_bus.kind == K_NONE && !commit_wr
            |=> illegal_o && $stable(acc_q) && $stable(flags_q))
        else $error("unknown opcode changed state");

    a_shr_imm_value: assert property (
        instr_valid_i && dec_bus.kind == K_SHR && dec_bus.cnt_imm
            |=> acc_q == $past(acc_q) >> $past(dec_bus.cnt))
        else $error("immediate shift value wrong");

    a_borrow_plain: assert property (
        instr_valid_i && dec_bus.kind == K_SUB && !dec_bus.dbl && !dec_bus.rev
            |=> flags_q[F_C] == ($past(acc_q) < $past(sext_operand(op_hi_i, op_lo_i))))
        else $error("carry differs from borrow");

    a_sat_in_range: assert property (
        instr_valid_i && dec_bus.kind == K_SUB && sat_en_q |=> !flags_q[F_E])
        else $error("saturated result out of range");

    c_shift_right: cover property (instr_valid_i && dec_bus.kind == K_SHR);
    c_reversed_double: cover property (instr_valid_i && dec_bus.kind == K_SUB
                                       && dec_bus.dbl && dec_bus.rev);
    c_store_word: cover property (store_valid_o);
    c_apb_read: cover property (pready_o && !pwrite_i);
    c_sticky_limit: cover property (flags_o[F_SL]);
endmodule // mac_sub_top

// File: verification/cpu_issuer.sv
// core pipeline side: issues one instruction with its two operand words
`timescale 1ns/1ps
module cpu_issuer import mac_sub_pkg::*; (
    input  wire logic          clock_i,         // core clock
    output logic               valid_o = 1'b0,  // instruction issued
    output logic [INSTR_W-1:0] instr_o = '0,    // instruction word
    output logic [WORD_W-1:0]  lo_o    = '0,    // first source word
    output logic [WORD_W-1:0]  hi_o    = '0     // second source word
);
    // between issues the words are inverted: the core does not hold them steady
    task issue(input logic [INSTR_W-1:0] i, input logic [WORD_W-1:0] l, h);
        @(posedge clock_i);
        valid_o <= 1'b1;
        instr_o <= i;
        lo_o <= l;
        hi_o <= h;
        @(posedge clock_i);
        valid_o <= 1'b0;
        instr_o <= ~i;
        lo_o <= ~l;
        hi_o <= ~h;
    endtask
endmodule // cpu_issuer

// File: verification/test_mac_acc_subtract_shift_store.sv
// self-checking bench: random instruction stream against a behavioural model
`timescale 1ns/1ps
module test_mac_acc_subtract_shift_store import mac_sub_pkg::*; ();
    logic        clock_i, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        iv, pready, pslverr, st_v, st_ind, post_v, ill, e, sat = 1'b0;
    logic [7:0]  paddr = '0, st_dest, b0;
    logic [31:0] pwdata = '0, prdata, iw, d, w, r, ins, rng = 32'h830a;
    logic [15:0] lo, hi, st_data, sd;
    logic [2:0]  post_code, q;
    logic [39:0] acc_o, acc = '0;
    logic [6:0]  flg, fl = '0;
    int          mismatches = 0, cmp_count = 0, cyc = 0, legal = 0;
    localparam logic [7:0] SUBS [4] = '{B2_SUB, B2_SUB2, B2_SUB2R, B2_SUBR};
    localparam logic [7:0] FIRST [3] = '{OP_RR, OP_RI, OP_XI};

    cpu_issuer u_cpu_issuer (.clock_i(clock_i), .valid_o(iv), .instr_o(iw), .lo_o(lo), .hi_o(hi));
    mac_sub_top u_mac_sub_top (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .instr_valid_i(iv),
        .instr_i(iw), .op_lo_i(lo), .op_hi_i(hi), .store_valid_o(st_v), .store_data_o(st_data),
        .store_ind_o(st_ind), .store_dest_o(st_dest), .post_mod_valid_o(post_v),
        .post_mod_code_o(post_code), .illegal_o(ill), .acc_o(acc_o), .flags_o(flg));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    function logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task chk(input string n, input logic [39:0] x, g);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int n;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64)
            mismatches++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task nze();
        fl[F_N] = acc[39];
        fl[F_Z] = (acc == 40'h0);
        fl[F_E] = !(&acc[39:31] || !(|acc[39:31]));
    endtask

    // exact 42-bit difference; N, Z and E flags come from the final, possibly clamped, value
    task sub_step(input logic dbl, rev);
        logic signed [41:0] o, a, x;
        o = $signed({{10{d[31]}}, d});
        if (dbl)
            o = o <<< 1;
        a = $signed({{2{acc[39]}}, acc});
        x = rev ? o - a : a - o;
        fl[F_C] = rev ? (o[39:0] < acc) : (acc < o[39:0]);
        fl[F_V] = (x[41:39] != 3'b000) && (x[41:39] != 3'b111);
        fl[F_SV] = fl[F_SV] | fl[F_V];
        acc = x[39:0];
        if (sat && (x[41:31] != '0) && (x[41:31] != '1)) begin
            acc = x[41] ? SAT_NEG : SAT_POS;
            fl[F_SL] = 1'b1;
        end
        nze();
    endtask

    task exec(input logic ok);
        u_cpu_issuer.issue(ins, d[15:0], d[31:16]);
        #1;
        chk("acc", acc, acc_o);
        chk("flags", 40'(fl), 40'(flg));
        chk("illegal", 40'(!ok), 40'(ill));
        chk("post_mod", 40'(ok && ins[7:0] inside {OP_RI, OP_XI, OP_ST_IND}), 40'(post_v));
        if (post_v === 1'b1)
            chk("post_code", 40'(ins[26:24]), 40'(post_code));
        chk("store_v", 40'(ok && ins[7:0] inside {OP_ST_DIR, OP_ST_IND}), 40'(st_v));
    endtask

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 240; k++) begin
            d = rnd();
            w = rnd();
            if (k == 120) begin
                apb(1'b1, A_CTRL, 32'h1);
                sat = 1'b1;
            end
            // a random guard byte pushes results toward the 40-bit limits
            if (k % 8 == 0) begin
                apb(1'b1, A_ACC_HI, w);
                acc[39:32] = w[7:0];
            end
            b0 = FIRST[w[9:8] % 3];
            q = (b0 == OP_RR) ? 3'h0 : w[2:0];
            case (w[12:10] % 6)
                0, 1, 2, 3: begin
                    ins = {5'h0, q, SUBS[w[11:10]], w[23:16], b0};
                    sub_step(w[11] ^ w[10], w[11]);
                end
                4: begin
                    if (w[13]) begin
                        ins = {8'(w[20:16] % 17), B2_SHR_IMM, B1_ZERO, OP_RR};
                        acc = acc >> ins[28:24];
                    end else begin
                        ins = {5'h0, q, B2_SHR_REG, w[23:16], (b0 == OP_RR) ? OP_RR : OP_RI};
                        acc = acc >> d[3:0];
                    end
                    fl[F_V] = 1'b0;
                    fl[F_C] = 1'b0;
                    nze();
                end
                default: begin
                    ins = {5'h0, w[13] ? w[2:0] : 3'h0, 3'h0, w[15:14], 3'h0, w[23:16],
                           w[13] ? OP_ST_IND : OP_ST_DIR};
                    sd = w[15] ? (w[14] ? 16'(fl) : 16'(acc[39:32]))
                               : (w[14] ? acc[31:16] : acc[15:0]);
                end
            endcase
            exec(1'b1);
            legal++;
            if (st_v === 1'b1) begin
                chk("store_data", 40'(sd), 40'(st_data));
                chk("store_dest", 40'({w[13], w[23:16]}), 40'({st_ind, st_dest}));
            end
        end
        ins = {8'h11, B2_SHR_IMM, B1_ZERO, OP_RR};
        exec(1'b0);
        apb(1'b0, A_ACC_LO, 32'h0);
        chk("acc_lo", 40'(acc[31:0]), 40'(r));
        apb(1'b0, A_STATUS, 32'h0);
        chk("status", 40'(16'(legal)), 40'(r));
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 40'h1, 40'(e));
        print_verdict();
    end
endmodule // test_mac_acc_subtract_shift_store
